// ===== bench/micp_core_model.sv
// memory stand-in of the core: stack writes and vector reads
module micp_core_model
  import micp_pkg::*;
(
  input logic clk_i,
  input logic reset_n_i,
  input micp_mem_t mem_i,
  input logic slow_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] stk [256];
  logic [2:0] wait_cnt;
  // ack after one cycle, or after four when slow; data toggles on every cycle without ack
  always_ff @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (!reset_n_i)
      wait_cnt <= '0;
    else if (mem_i.req && !ack_o)
    begin
      wait_cnt <= wait_cnt + 3'd1;
      if (!slow_i || wait_cnt == 3'd3)
      begin
        ack_o <= 1'b1;
        wait_cnt <= '0;
        rdata_o <= mem_i.addr[7:0]; // a vector byte reads its address
        if (mem_i.we)
          stk[mem_i.addr[7:0]] <= mem_i.wdata;
      end
    end
  end
endmodule // micp_core_model

// ===== bench/micp_ctrl_sva.sv
// port-level assertions of the interrupt priority controller
module micp_ctrl_sva
  import micp_pkg::*;
(
  input logic clk_i,
  input logic reset_n_i,
  input logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  input logic s_axi_arvalid_i,
  input logic s_axi_arready_o,
  input logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  input logic [31:0] s_axi_rdata_o,
  input logic break_instruction_i,
  input logic boundary_i,
  input logic [15:0] pc_i,
  input logic [7:0] sp_i,
  input micp_mem_t mem_o,
  input logic mem_ack_i,
  input logic irq_o,
  input logic halt_o,
  input logic pc_load_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  chk_load_one_cycle: assert property (
    pc_load_o |=> !pc_load_o) else $error("pc load held too long");
  chk_mem_req_hold: assert property (
    mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o))
    else $error("memory request changed before ack");
  chk_mem_ack_drop: assert property (
    mem_o.req && mem_ack_i |=> !mem_o.req)
    else $error("memory request kept after ack");
  chk_accept_push_pch: assert property (
    !halt_o && boundary_i && irq_o |-> ##2 halt_o && mem_o.req && mem_o.we
    && mem_o.addr == {STACK_PAGE, $past(sp_i, 2)}
    && mem_o.wdata == $past(pc_i[15:8], 2))
    else $error("acceptance did not push pc high byte");
  chk_break_raises: assert property (
    break_instruction_i |=> irq_o) else $error("break not raised");
  chk_read_answer: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  chk_read_hold: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read data dropped");
  chk_write_resp_hold: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped");
endmodule // micp_ctrl_sva

bind micp_ctrl micp_ctrl_sva chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rdata_o(s_axi_rdata_o), .break_instruction_i(break_instruction_i),
  .boundary_i(boundary_i), .pc_i(pc_i), .sp_i(sp_i), .mem_o(mem_o),
  .mem_ack_i(mem_ack_i), .irq_o(irq_o), .halt_o(halt_o),
  .pc_load_o(pc_load_o));

// ===== bench/tb.sv
// self-checking bench of the interrupt priority controller
module tb
  import micp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_n_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, break_instruction, boundary, slow, ack;
  logic irq, halt, pc_load;
  logic [7:0] awaddr, araddr, ps, sp, mrdata, new_sp, key_dir;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0] bresp, rresp, rd_resp, wr_resp;
  logic [15:0] pc, new_pc;
  micp_pins_t pins;
  micp_evt_t evt;
  micp_mem_t mem;
  int errors, total_checks;

  micp_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_arprot_i(3'h0), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .pins_i(pins), .key_dir_out_i(key_dir),
    .evt_i(evt), .break_instruction_i(break_instruction), .boundary_i(boundary),
    .pc_i(pc), .ps_i(ps), .sp_i(sp), .mem_o(mem), .mem_ack_i(ack),
    .mem_rdata_i(mrdata), .irq_o(irq), .halt_o(halt),
    .pc_load_o(pc_load), .new_pc_o(new_pc), .new_sp_o(new_sp));

  micp_core_model core (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .mem_i(mem), .slow_i(slow), .ack_o(ack), .rdata_o(mrdata));

  // free-running clock
  initial
    forever #2.5 clk_i = ~clk_i;

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one waited cycle; a used-up bound is a mismatch and ends the run
  task automatic limit(inout int n);
    n++;
    if (n > 300)
    begin
      errors++;
      $display("Error at %0t: wait timed out", $time);
      give_verdict();
    end
  endtask

  // wait at falling edges for bvalid (0), rvalid (1) or pc load (2)
  task automatic wait_hi(input int w);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_i);
      limit(n);
    end
    while ((w == 0 ? bvalid : w == 1 ? rvalid : pc_load) !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    int n;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    @(posedge clk_i);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    while (!(aw_done && w_done))
    begin
      @(negedge clk_i);
      aw_done |= awvalid && awready;
      w_done |= wvalid && wready;
      limit(n);
      @(posedge clk_i);
      if (aw_done)
        awvalid <= 1'b0;
      if (w_done)
        wvalid <= 1'b0;
    end
    wait_hi(0);
    @(posedge clk_i);
    bready <= 1'b1;
    @(negedge clk_i);
    wr_resp = bresp;
    @(posedge clk_i);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk_i);
    arvalid <= 1'b1;
    araddr <= a;
    while (!got)
    begin
      @(negedge clk_i);
      got = arready;
      limit(n);
      @(posedge clk_i);
    end
    arvalid <= 1'b0;
    wait_hi(1);
    @(posedge clk_i);
    rready <= 1'b1;
    @(negedge clk_i);
    rd_data = rdata;
    rd_resp = rresp;
    @(posedge clk_i);
    rready <= 1'b0;
  endtask

  task automatic pulse(input micp_evt_t e, input logic b);
    @(posedge clk_i);
    evt <= e;
    break_instruction <= b;
    @(posedge clk_i);
    evt <= '0;
    break_instruction <= 1'b0;
  endtask

  // wait for the handler load, then judge vector and stack frame
  task automatic entry(input logic [15:0] exp_pc);
    wait_hi(2);
    check(32'(new_pc), 32'(exp_pc));
    check(32'(new_sp), 32'(sp - STACK_FRAME));
    check(32'(core.stk[sp]), 32'(pc[15:8]));
    check(32'(core.stk[sp - 8'd1]), 32'(pc[7:0]));
    check(32'(core.stk[sp - 8'd2]), 32'(ps));
  endtask

  task automatic s_reset();
    wait_hi(2);
    check(32'(new_pc), 32'h0000_FDFC);
    rd(MICP_OFS_CTRL);
    check(rd_data, 32'h0000_0001);
    rd(MICP_OFS_ENA);
    check(rd_data, 32'h0000_0000);
  endtask

  task automatic s_regs();
    wr(MICP_OFS_ENA, 32'h0000_7FFF);
    rd(MICP_OFS_ENA);
    check(rd_data, 32'h0000_7FFF);
    wr(MICP_OFS_ENA, 32'h0000_0000);
    rd(MICP_OFS_ENA);
    check(rd_data, 32'h0000_0000);
    wr(MICP_OFS_REQ, 32'hFFFF_FFFF);
    rd(MICP_OFS_REQ);
    check(rd_data, 32'h0000_0000);
    rd(8'h10);
    check(32'(rd_resp), 32'(RESP_SLVERR));
    wr(8'h10, 32'h0000_0001);
    check(32'(wr_resp), 32'(RESP_SLVERR));
  endtask

  task automatic s_mask();
    boundary <= 1'b0;
    pulse('{tmr3: 1'b1, default: 1'b0}, 1'b0);
    rd(MICP_OFS_REQ);
    check(rd_data, 32'h0000_0400);
    @(negedge clk_i);
    check(32'(irq), 32'h0);
    wr(MICP_OFS_ENA, 32'h0000_0400);
    @(negedge clk_i);
    check(32'(irq), 32'h0);
    wr(MICP_OFS_CTRL, 32'h0000_0000);
    @(negedge clk_i);
    check(32'(irq), 32'h1);
    slow <= 1'b1;
    boundary <= 1'b1;
    entry(16'hE7E6);
    slow <= 1'b0;
    rd(MICP_OFS_REQ);
    check(rd_data, 32'h0000_0000);
    rd(MICP_OFS_CTRL);
    check(rd_data, 32'h0000_0001);
  endtask

  task automatic s_prio();
    boundary <= 1'b0;
    pc <= 16'h5A3C;
    ps <= 8'h81;
    sp <= 8'hC0;
    pins.ext_irq_pin1 <= 1'b0;
    pulse('{tmr_x: 1'b1, tmr4: 1'b1, default: 1'b0}, 1'b0);
    wr(MICP_OFS_ENA, 32'h0000_7FFF);
    wr(MICP_OFS_CTRL, 32'h0000_0000);
    boundary <= 1'b1;
    entry(16'hF9F8);
    wr(MICP_OFS_CTRL, 32'h0000_0000);
    entry(16'hEDEC);
    wr(MICP_OFS_CTRL, 32'h0000_0000);
    entry(16'hE5E4);
  endtask

  task automatic s_break();
    wr(MICP_OFS_ENA, 32'h0000_0000);
    pulse('0, 1'b1);
    entry(16'hDDDC);
  endtask

  // edge change by the safe sequence, then only the chosen edge requests
  task automatic s_edge();
    wr(MICP_OFS_ENA, 32'h0000_0000);
    wr(MICP_OFS_CTRL, 32'h0000_0101);
    rd(MICP_OFS_REQ);
    check(rd_data, 32'h0000_0001);
    wr(MICP_OFS_REQ, 32'h0000_7FFE);
    rd(MICP_OFS_REQ);
    check(rd_data, 32'h0000_0000);
    wr(MICP_OFS_ENA, 32'h0000_0001);
    pins.ext_irq_pin0 <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(MICP_OFS_REQ);
    check(rd_data, 32'h0000_0000);
    pins.ext_irq_pin0 <= 1'b1;
    wr(MICP_OFS_CTRL, 32'h0000_0100);
    entry(16'hFBFA);
  endtask

  // key matrix owns the shared slot; output-mode keys and pin 2 are ignored
  task automatic s_key();
    wr(MICP_OFS_ENA, 32'h0000_0000);
    wr(MICP_OFS_CTRL, 32'h0101_0101);
    wr(MICP_OFS_REQ, 32'h0000_7FFB);
    key_dir <= 8'h01;
    pins.ext_irq_pin2 <= 1'b0;
    pins.key[0] <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(MICP_OFS_REQ);
    check(rd_data, 32'h0000_0000);
    pins.key[3] <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(MICP_OFS_REQ);
    check(rd_data, 32'h0000_0004);
    wr(MICP_OFS_ENA, 32'h0000_0004);
    wr(MICP_OFS_CTRL, 32'h0101_0100);
    entry(16'hF7F6);
  endtask

  // serial 1 receive and timer 1 count only while their source is selected
  task automatic s_sel();
    pulse('{sio1_rx: 1'b1, tmr1: 1'b1, default: 1'b0}, 1'b0);
    rd(MICP_OFS_REQ);
    check(rd_data, 32'h0000_0000);
    wr(MICP_OFS_CTRL, 32'h000A_0001);
    pulse('{sio1_rx: 1'b1, tmr1: 1'b1, default: 1'b0}, 1'b0);
    rd(MICP_OFS_REQ);
    check(rd_data, 32'h0000_0108);
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    reset_n_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, break_instruction, slow} = '0;
    boundary = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    pins = '1;
    key_dir = '0;
    evt = '0;
    pc = 16'h8421;
    ps = 8'h24;
    sp = 8'hFF;
    errors = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    s_reset();
    s_regs();
    s_mask();
    s_prio();
    s_break();
    s_edge();
    s_key();
    s_sel();
    give_verdict();
  end
endmodule // tb

// ===== logic/micp_ctrl.sv
// interrupt priority controller with request latching and vector sequencer
module micp_ctrl
  import micp_pkg::*;
(
  input logic clk_i,
  input logic reset_n_i,
  input logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input logic [7:0] s_axi_awaddr_i,
  input logic [2:0] s_axi_awprot_i,
  input logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input logic [31:0] s_axi_wdata_i,
  input logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input logic [7:0] s_axi_araddr_i,
  input logic [2:0] s_axi_arprot_i,
  output logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input micp_pins_t pins_i,
  input logic [7:0] key_dir_out_i,
  input micp_evt_t evt_i,
  input logic break_instruction_i,
  input logic boundary_i,
  input logic [15:0] pc_i,
  input logic [7:0] ps_i,
  input logic [7:0] sp_i,
  output micp_mem_t mem_o,
  input logic mem_ack_i,
  input logic [7:0] mem_rdata_i,
  output logic irq_o,
  output logic halt_o,
  output logic pc_load_o,
  output logic [15:0] new_pc_o,
  output logic [7:0] new_sp_o
);

  micp_state_t s_reg;
  micp_state_t s_next;

  // register decode: bit 2 is a hit, low bits the register index
  function automatic logic [2:0] decode(input logic [7:0] a);
    logic [2:0] r;
    r = 3'b000;
    if (a[7:2] == MICP_OFS_REQ[7:2])
      r = 3'b100;
    else if (a[7:2] == MICP_OFS_ENA[7:2])
      r = 3'b101;
    else if (a[7:2] == MICP_OFS_CTRL[7:2])
      r = 3'b110;
    else if (a[7:2] == MICP_OFS_STAT[7:2])
      r = 3'b111;
    return r;
  endfunction

  // expand byte strobes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] st);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = {8{st[i]}};
    return m;
  endfunction

  // index of the lowest set slot, which is the highest priority
  function automatic logic [3:0] first_set(input logic [14:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = MICP_NSLOT - 1; i >= 0; i--)
      if (v[i])
        idx = 4'(i);
    return idx;
  endfunction

  logic [4:0] pin_lvl;
  logic [7:0] key_lvl;
  logic [4:0] eff;
  logic key_and;
  logic key_eff;
  logic [4:0] lvl;
  logic [4:0] rise;
  logic [14:0] set_vec;
  logic [14:0] pending;
  logic mask_irq;
  logic [3:0] win_slot;

  // synchronised pin levels in active sense; flipping polarity makes an edge
  // the first struct member is the top bit, so unpack by field name
  micp_pins_t pin_s;
  assign pin_s = s_reg.sync2;
  assign pin_lvl = {pin_s.counter_input1, pin_s.counter_input0,
                    pin_s.ext_irq_pin2, pin_s.ext_irq_pin1, pin_s.ext_irq_pin0};
  assign key_lvl = pin_s.key;
  assign eff = pin_lvl ^ ~s_reg.edge_rise;
  // output-mode key pins read as one so they never pull the AND low
  assign key_and = &(key_lvl | key_dir_out_i);
  assign key_eff = s_reg.key_ctrl & ~key_and;

  // level per edge slot; shared slots mux before the edge so a switch can hit
  assign lvl[0] = eff[EDGE_PIN0];
  assign lvl[1] = eff[EDGE_PIN1];
  assign lvl[2] = s_reg.sel[SEL_KEY] ? key_eff : eff[EDGE_PIN2];
  assign lvl[3] = eff[EDGE_CNT0];
  assign lvl[4] = s_reg.sel[SEL_CNT1] ? eff[EDGE_CNT1] : evt_i.tmr_y;
  assign rise = lvl & ~s_reg.lvl_prev;

  // hardware set events per slot
  assign set_vec[SLOT_PIN0] = rise[0];
  assign set_vec[SLOT_PIN1] = rise[1];
  assign set_vec[SLOT_PIN2] = rise[2];
  assign set_vec[SLOT_S1RX] = evt_i.sio1_rx & s_reg.sel[SEL_SIO1];
  assign set_vec[SLOT_S1TX] = evt_i.sio1_tx & s_reg.sel[SEL_SIO1];
  assign set_vec[SLOT_S2RX] = evt_i.sio2_rx & s_reg.sel[SEL_SIO2];
  assign set_vec[SLOT_S2TX] = evt_i.sio2_tx & s_reg.sel[SEL_SIO2];
  assign set_vec[SLOT_TMRX] = evt_i.tmr_x;
  assign set_vec[SLOT_TMR1] = evt_i.tmr1 & s_reg.sel[SEL_TMR1];
  assign set_vec[SLOT_TMR2] = evt_i.tmr2 & s_reg.sel[SEL_TMR2];
  assign set_vec[SLOT_TMR3] = evt_i.tmr3;
  assign set_vec[SLOT_TMR4] = evt_i.tmr4;
  assign set_vec[SLOT_CNT0] = rise[3];
  assign set_vec[SLOT_TMRY] = rise[4];
  assign set_vec[SLOT_ADC] = evt_i.adc_done & s_reg.sel[SEL_ADC];

  // request gating toward the core
  assign pending = s_reg.req & s_reg.ena;
  assign mask_irq = (|pending) & ~s_reg.iflag;
  assign irq_o = mask_irq | s_reg.break_pend;
  assign win_slot = first_set(pending);

  // handshake and core-facing outputs
  assign s_axi_awready_o = ~s_reg.aw_got & ~s_reg.bvalid;
  assign s_axi_wready_o = ~s_reg.w_got & ~s_reg.bvalid;
  assign s_axi_arready_o = ~s_reg.rvalid;
  assign s_axi_bvalid_o = s_reg.bvalid;
  assign s_axi_bresp_o = s_reg.bresp;
  assign s_axi_rvalid_o = s_reg.rvalid;
  assign s_axi_rdata_o = s_reg.rdata;
  assign s_axi_rresp_o = s_reg.rresp;
  assign mem_o = s_reg.mem;
  assign halt_o = s_reg.seq != SEQ_IDLE;
  assign pc_load_o = s_reg.seq == SEQ_LOAD;
  assign new_pc_o = s_reg.new_pc;
  assign new_sp_o = s_reg.sp_cap;

  logic [14:0] sw_clr;
  logic [14:0] hw_clr;
  logic [31:0] wmask;
  logic [2:0] wdec;
  logic [2:0] rdec;
  logic [31:0] rword;
  logic is_mem;
  logic cmd_we;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_data;
  micp_seq_t cmd_next;

  // next-state logic for bus slave, request latches and sequencer
  always_comb
  begin
    s_next = s_reg;
    sw_clr = '0;
    hw_clr = '0;
    wmask = lane_mask(s_reg.wstrb);
    wdec = decode(s_reg.aw_addr);
    rdec = decode(s_axi_araddr_i);
    rword = '0;
    is_mem = 1'b1;
    cmd_we = 1'b0;
    cmd_addr = '0;
    cmd_data = '0;
    cmd_next = SEQ_IDLE;

    // write address and data are taken in either order
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata_i;
      s_next.wstrb = s_axi_wstrb_i;
    end
    if (s_reg.bvalid && s_axi_bready_i)
      s_next.bvalid = 1'b0;

    // register write once both halves are held
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wdec[2] ? RESP_OKAY : RESP_SLVERR;
      unique case ({wdec[2], wdec[1:0]})
        3'b100: sw_clr = ~s_reg.wdata[14:0] & wmask[14:0];
        3'b101: s_next.ena = (s_reg.ena & ~wmask[14:0])
                             | (s_reg.wdata[14:0] & wmask[14:0]);
        3'b110:
        begin
          if (s_reg.wstrb[0])
            s_next.iflag = s_reg.wdata[CTRL_IFLAG_BIT];
          if (s_reg.wstrb[1])
            s_next.edge_rise = s_reg.wdata[CTRL_EDGE_LSB +: 5];
          if (s_reg.wstrb[2])
            s_next.sel = s_reg.wdata[CTRL_SEL_LSB +: 7];
          if (s_reg.wstrb[3])
            s_next.key_ctrl = s_reg.wdata[CTRL_KEYCTL_BIT];
        end
        default: ; // status is read only, misses answer with an error
      endcase
    end

    // read path answers one cycle after the address is taken
    if (s_reg.rvalid && s_axi_rready_i)
      s_next.rvalid = 1'b0;
    unique case (rdec[1:0])
      2'b00: rword[14:0] = s_reg.req;
      2'b01: rword[14:0] = s_reg.ena;
      2'b10:
      begin
        rword[CTRL_IFLAG_BIT] = s_reg.iflag;
        rword[CTRL_EDGE_LSB +: 5] = s_reg.edge_rise;
        rword[CTRL_SEL_LSB +: 7] = s_reg.sel;
        rword[CTRL_KEYCTL_BIT] = s_reg.key_ctrl;
      end
      2'b11:
      begin
        rword[STAT_IRQ_BIT] = irq_o;
        rword[STAT_HALT_BIT] = halt_o;
        rword[STAT_BREAK_BIT] = s_reg.break_pend;
        rword[STAT_SLOT_LSB +: 4] = s_reg.slot;
        rword[STAT_KEY_LSB +: 8] = key_lvl;
      end
    endcase
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rdec[2] ? rword : '0;
      s_next.rresp = rdec[2] ? RESP_OKAY : RESP_SLVERR;
    end

    // acceptance at an instruction boundary
    if (s_reg.seq == SEQ_IDLE && boundary_i && irq_o)
    begin
      s_next.iflag = 1'b1;
      s_next.pc_cap = pc_i;
      s_next.ps_cap = ps_i;
      s_next.sp_cap = sp_i;
      s_next.seq = SEQ_PUSH_PCH;
      if (mask_irq)
      begin
        // maskable slots all outrank the break instruction
        s_next.slot = win_slot;
        hw_clr[win_slot] = 1'b1;
        s_next.vec_lo = VEC_SLOT0_LO - {11'h000, win_slot, 1'b0};
      end
      else
      begin
        s_next.break_pend = 1'b0;
        s_next.vec_lo = VEC_BREAK_LO;
      end
    end

    // bus command for each sequencer step
    unique case (s_reg.seq)
      SEQ_RST_LO:
      begin
        s_next.iflag = 1'b1;
        cmd_addr = VEC_RESET_LO;
        cmd_next = SEQ_RST_HI;
      end
      SEQ_RST_HI:
      begin
        cmd_addr = VEC_RESET_LO + 16'h0001;
        cmd_next = SEQ_LOAD;
      end
      SEQ_PUSH_PCH:
      begin
        cmd_we = 1'b1;
        cmd_addr = {STACK_PAGE, s_reg.sp_cap};
        cmd_data = s_reg.pc_cap[15:8];
        cmd_next = SEQ_PUSH_PCL;
      end
      SEQ_PUSH_PCL:
      begin
        cmd_we = 1'b1;
        cmd_addr = {STACK_PAGE, s_reg.sp_cap - 8'h01};
        cmd_data = s_reg.pc_cap[7:0];
        cmd_next = SEQ_PUSH_PS;
      end
      SEQ_PUSH_PS:
      begin
        cmd_we = 1'b1;
        cmd_addr = {STACK_PAGE, s_reg.sp_cap - 8'h02};
        cmd_data = s_reg.ps_cap;
        cmd_next = SEQ_VEC_LO;
      end
      SEQ_VEC_LO:
      begin
        cmd_addr = s_reg.vec_lo;
        cmd_next = SEQ_VEC_HI;
      end
      SEQ_VEC_HI:
      begin
        cmd_addr = s_reg.vec_lo + 16'h0001;
        cmd_next = SEQ_LOAD;
      end
      SEQ_IDLE:
        is_mem = 1'b0;
      SEQ_LOAD:
      begin
        is_mem = 1'b0;
        s_next.seq = SEQ_IDLE;
      end
      default:
      begin
        is_mem = 1'b0;
        s_next.seq = SEQ_IDLE;
      end
    endcase

    // issue the step, then wait for the memory acknowledge
    if (is_mem && !s_reg.mem.req)
    begin
      s_next.mem.req = 1'b1;
      s_next.mem.we = cmd_we;
      s_next.mem.addr = cmd_addr;
      s_next.mem.wdata = cmd_data;
    end
    else if (is_mem && mem_ack_i)
    begin
      s_next.mem.req = 1'b0;
      s_next.seq = cmd_next;
      if (s_reg.seq == SEQ_RST_LO || s_reg.seq == SEQ_VEC_LO)
        s_next.new_pc[7:0] = mem_rdata_i;
      if (s_reg.seq == SEQ_RST_HI || s_reg.seq == SEQ_VEC_HI)
        s_next.new_pc[15:8] = mem_rdata_i;
      if (s_reg.seq == SEQ_PUSH_PS)
        s_next.sp_cap = s_reg.sp_cap - STACK_FRAME;
    end

    // latches hold until cleared; a same-cycle set beats any clear
    s_next.req = (s_reg.req & ~sw_clr & ~hw_clr) | set_vec;
    s_next.break_pend = s_next.break_pend | break_instruction_i;

    // pin synchronisers and edge history
    s_next.sync1 = pins_i;
    s_next.sync2 = s_reg.sync1;
    s_next.lvl_prev = lvl;
  end

  // state register, synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      s_reg <= MICP_STATE_RST;
    else
      s_reg <= s_next;
  end

endmodule // micp_ctrl

// ===== logic/micp_pkg.sv
// constants, carriers and state layout of the interrupt priority controller
package micp_pkg;
  localparam int MICP_NSLOT = 15;
  // register byte offsets
  localparam logic [7:0] MICP_OFS_REQ = 8'h00;
  localparam logic [7:0] MICP_OFS_ENA = 8'h04;
  localparam logic [7:0] MICP_OFS_CTRL = 8'h08;
  localparam logic [7:0] MICP_OFS_STAT = 8'h0C;
  // control register field positions
  localparam int CTRL_IFLAG_BIT = 0;
  localparam int CTRL_EDGE_LSB = 8;
  localparam int CTRL_SEL_LSB = 16;
  localparam int CTRL_KEYCTL_BIT = 24;
  // status register field positions
  localparam int STAT_IRQ_BIT = 0;
  localparam int STAT_HALT_BIT = 1;
  localparam int STAT_BREAK_BIT = 2;
  localparam int STAT_SLOT_LSB = 4;
  localparam int STAT_KEY_LSB = 16;
  // edge select indices, also sync pin order
  localparam int EDGE_PIN0 = 0;
  localparam int EDGE_PIN1 = 1;
  localparam int EDGE_PIN2 = 2;
  localparam int EDGE_CNT0 = 3;
  localparam int EDGE_CNT1 = 4;
  // source select indices
  localparam int SEL_KEY = 0;
  localparam int SEL_SIO1 = 1;
  localparam int SEL_SIO2 = 2;
  localparam int SEL_TMR1 = 3;
  localparam int SEL_TMR2 = 4;
  localparam int SEL_ADC = 5;
  localparam int SEL_CNT1 = 6;
  // request slots, index is priority minus two
  localparam int SLOT_PIN0 = 0;
  localparam int SLOT_PIN1 = 1;
  localparam int SLOT_PIN2 = 2;
  localparam int SLOT_S1RX = 3;
  localparam int SLOT_S1TX = 4;
  localparam int SLOT_S2RX = 5;
  localparam int SLOT_S2TX = 6;
  localparam int SLOT_TMRX = 7;
  localparam int SLOT_TMR1 = 8;
  localparam int SLOT_TMR2 = 9;
  localparam int SLOT_TMR3 = 10;
  localparam int SLOT_TMR4 = 11;
  localparam int SLOT_CNT0 = 12;
  localparam int SLOT_TMRY = 13;
  localparam int SLOT_ADC = 14;
  // vectors and stack
  localparam logic [15:0] VEC_SLOT0_LO = 16'hFFFA;
  localparam logic [15:0] VEC_RESET_LO = 16'hFFFC;
  localparam logic [15:0] VEC_BREAK_LO = 16'hFFDC;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] STACK_FRAME = 8'h03;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    SEQ_RST_LO, SEQ_RST_HI, SEQ_IDLE, SEQ_PUSH_PCH, SEQ_PUSH_PCL,
    SEQ_PUSH_PS, SEQ_VEC_LO, SEQ_VEC_HI, SEQ_LOAD
  } micp_seq_t;

  typedef struct packed {
    logic ext_irq_pin0;
    logic ext_irq_pin1;
    logic ext_irq_pin2;
    logic counter_input0;
    logic counter_input1;
    logic [7:0] key;
  } micp_pins_t;

  typedef struct packed {
    logic sio1_rx;
    logic sio1_tx;
    logic sio2_rx;
    logic sio2_tx;
    logic tmr_x;
    logic tmr1;
    logic tmr2;
    logic tmr3;
    logic tmr4;
    logic tmr_y;
    logic adc_done;
  } micp_evt_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } micp_mem_t;

  typedef struct packed {
    logic [14:0] req;
    logic [14:0] ena;
    logic iflag;
    logic [4:0] edge_rise;
    logic [6:0] sel;
    logic key_ctrl;
    logic [12:0] sync1;
    logic [12:0] sync2;
    logic [4:0] lvl_prev;
    logic break_pend;
    micp_seq_t seq;
    logic [3:0] slot;
    logic [15:0] vec_lo;
    logic [15:0] pc_cap;
    logic [7:0] ps_cap;
    logic [7:0] sp_cap;
    logic [15:0] new_pc;
    micp_mem_t mem;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } micp_state_t;

  // syncs and edge history start high so release makes no false edge
  localparam micp_state_t MICP_STATE_RST = '{
    sync1: '1, sync2: '1, lvl_prev: '1, seq: SEQ_RST_LO, default: '0};
endpackage
